//--- ccbb_port.sv
// channel port: cpu-style fifo access and async/sync bit-bang engine
`timescale 1ns/1ps
`default_nettype none
module ccbb_port #(
    parameter int DIV_W = 16
) (
    input  wire logic                    ref_clk_i,
    input  wire logic                    rst_n_i,
    input  wire ccbb_pkg::ccbb_cfg_e     cfg_mode_i,
    input  wire logic                    mode_cmd_valid_i,
    input  wire ccbb_pkg::ccbb_mode_cmd_s mode_cmd_i,
    input  wire logic [DIV_W-1:0]        baud_div_i,
    input  wire ccbb_pkg::ccbb_usb_state_s usb_state_i,
    input  wire logic                    rx_valid_i,
    output logic                         rx_ready_o,
    input  wire logic [7:0]              rx_data_i,
    output logic                         tx_valid_o,
    input  wire logic                    tx_ready_i,
    output logic [7:0]                   tx_data_o,
    output logic                         flush_o,
    input  wire logic                    cs_n_i,
    input  wire logic                    port_address_bit_i,
    input  wire logic                    rd_n_i,
    input  wire logic                    wr_n_i,
    input  wire logic [7:0]              data_i,
    output logic [7:0]                   data_o,
    output logic [7:0]                   data_oe_o,
    output logic                         sample_done_strobe_n_o,
    output logic                         output_update_strobe_n_o
);
    typedef enum logic [1:0] {
        CCBB_M_FIFO,
        CCBB_M_ASYNC,
        CCBB_M_SYNC
    } ccbb_mode_e;

    typedef enum logic [2:0] {
        CCBB_S_IDLE,
        CCBB_S_SEND,
        CCBB_S_CHANGE,
        CCBB_S_SETUP,
        CCBB_S_STROBE
    } ccbb_sync_e;

    ccbb_mode_e mode;
    ccbb_mode_e next_mode;
    ccbb_sync_e sst;
    ccbb_sync_e next_sst;
    logic [7:0] dir;
    logic [7:0] next_dir;
    logic [7:0] pin_q;
    logic [7:0] next_pin_q;
    logic [7:0] oe_q;
    logic [7:0] next_oe_q;
    logic [7:0] rd_byte;
    logic [7:0] next_rd_byte;
    logic [7:0] hold_byte;
    logic [7:0] next_hold_byte;
    logic       sdn_q;
    logic       next_sdn_q;
    logic       udn_q;
    logic       next_udn_q;
    logic       rd_n_q;
    logic       wr_n_q;
    // flush counter sized to its reload value
    localparam int FL_W = $clog2(ccbb_pkg::FLUSH_CYC + 1);
    logic [FL_W-1:0] fl_cnt;
    logic [FL_W-1:0] next_fl_cnt;
    logic       flush_q;
    logic       next_flush_q;
    logic       tick;
    logic       bf_in_valid;
    logic       bf_in_ready;
    logic [7:0] bf_in_data;
    logic       rx_take;

    ccbb_baud #(
        .DIV_W(DIV_W)
    ) u_baud (
        .ref_clk_i(ref_clk_i),
        .rst_n_i  (rst_n_i),
        .div_i    (baud_div_i),
        .tick_o   (tick)
    );

    // output buffer absorbs tx stalls; sync samples wait for space, but a cpu write into a full buffer is lost
    ccbb_buf2 #(
        .WIDTH(8),
        .DEPTH(2)
    ) u_txbuf (
        .ref_clk_i  (ref_clk_i),
        .rst_n_i    (rst_n_i),
        .in_valid_i (bf_in_valid),
        .in_ready_o (bf_in_ready),
        .in_data_i  (bf_in_data),
        .out_valid_o(tx_valid_o),
        .out_ready_i(tx_ready_i),
        .out_data_o (tx_data_o)
    );

    wire cpu_sel   = (mode == CCBB_M_FIFO)
                     && (cfg_mode_i == ccbb_pkg::CCBB_FIFO_CPU);
    wire rd_fall   = rd_n_q && !rd_n_i;
    wire wr_fall   = wr_n_q && !wr_n_i;
    wire cpu_go    = cpu_sel && !cs_n_i;
    wire rd_data   = cpu_go && rd_fall
                     && (port_address_bit_i == ccbb_pkg::ADDR_DATA);
    wire rd_stat   = cpu_go && rd_fall
                     && (port_address_bit_i == ccbb_pkg::ADDR_STATUS);
    wire wr_data   = cpu_go && wr_fall
                     && (port_address_bit_i == ccbb_pkg::ADDR_DATA);
    wire wr_flush  = cpu_go && wr_fall
                     && (port_address_bit_i == ccbb_pkg::ADDR_STATUS);

    wire sync_start = (mode == CCBB_M_SYNC) && (sst == CCBB_S_IDLE)
                      && rx_valid_i && bf_in_ready && !mode_cmd_valid_i;
    wire async_take = (mode == CCBB_M_ASYNC) && rx_valid_i && tick;

    always_comb
    begin
        rx_take = sync_start || async_take || (rd_data && rx_valid_i);
        rx_ready_o  = rx_take;
        bf_in_valid = 1'b0;
        bf_in_data  = data_i;
        if (wr_data)
            bf_in_valid = 1'b1;
        else if (sst == CCBB_S_SEND)
            bf_in_valid = 1'b1;
        if (sst == CCBB_S_SEND)
            bf_in_data = hold_byte;
    end

    always_comb
    begin
        next_mode      = mode;
        next_dir       = dir;
        next_sst       = sst;
        next_pin_q     = pin_q;
        next_oe_q      = oe_q;
        next_rd_byte   = rd_byte;
        next_hold_byte = hold_byte;
        next_sdn_q     = 1'b1;
        next_udn_q     = 1'b1;
        next_fl_cnt    = fl_cnt;
        next_flush_q   = 1'b0;
        if (mode_cmd_valid_i)
        begin
            next_dir = mode_cmd_i.dir_mask;
            next_sst = CCBB_S_IDLE;
            case (mode_cmd_i.code)
                ccbb_pkg::MODE_ASYNC_BANG: next_mode = CCBB_M_ASYNC;
                ccbb_pkg::MODE_SYNC_BANG:  next_mode = CCBB_M_SYNC;
                default:                   next_mode = CCBB_M_FIFO;
            endcase
        end
        next_oe_q = (mode == CCBB_M_FIFO) ? '0 : dir;
        if (mode == CCBB_M_FIFO)
        begin
            if (cpu_sel && !cs_n_i && !rd_n_i)
                next_oe_q = '1;
            if (rd_stat)
                next_rd_byte = {ccbb_pkg::ST_UPPER,
                                usb_state_i.configured,
                                usb_state_i.suspend,
                                usb_state_i.tx_space,
                                usb_state_i.rx_avail};
            else if (rd_data)
                next_rd_byte = rx_data_i;
            next_pin_q = rd_byte;
            if (rd_stat || rd_data)
                next_pin_q = next_rd_byte;
        end
        if (async_take)
        begin
            next_pin_q = rx_data_i;
            next_udn_q = 1'b0;
        end
        if ((mode == CCBB_M_ASYNC) && tick && !rx_valid_i)
            next_sdn_q = 1'b0;
        case (sst)
            CCBB_S_IDLE:
            begin
                if (sync_start && !mode_cmd_valid_i)
                begin
                    next_hold_byte = data_i;
                    next_rd_byte   = rx_data_i;
                    next_sst       = CCBB_S_SEND;
                end
            end
            CCBB_S_SEND:
            begin
                next_sdn_q = 1'b0;
                next_sst   = CCBB_S_CHANGE;
            end
            CCBB_S_CHANGE:
            begin
                next_pin_q = rd_byte;
                next_sst   = CCBB_S_SETUP;
            end
            CCBB_S_SETUP:
                next_sst = CCBB_S_STROBE;
            CCBB_S_STROBE:
            begin
                next_udn_q = 1'b0;
                next_sst   = CCBB_S_IDLE;
            end
            default:
                next_sst = CCBB_S_IDLE;
        endcase
        // flush pulse held its minimum width
        if (wr_flush)
            next_fl_cnt = FL_W'(ccbb_pkg::FLUSH_CYC);
        else if (fl_cnt != '0)
            next_fl_cnt = fl_cnt - FL_W'(1);
        next_flush_q = (next_fl_cnt != '0);
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode      <= CCBB_M_FIFO;
            sst       <= CCBB_S_IDLE;
            dir       <= ccbb_pkg::DIR_RST;
            pin_q     <= '0;
            oe_q      <= '0;
            rd_byte   <= '0;
            hold_byte <= '0;
            sdn_q     <= 1'b1;
            udn_q     <= 1'b1;
            rd_n_q    <= 1'b1;
            wr_n_q    <= 1'b1;
            fl_cnt    <= '0;
            flush_q   <= 1'b0;
        end
        else
        begin
            mode      <= next_mode;
            sst       <= next_sst;
            dir       <= next_dir;
            pin_q     <= next_pin_q;
            oe_q      <= next_oe_q;
            rd_byte   <= next_rd_byte;
            hold_byte <= next_hold_byte;
            sdn_q     <= next_sdn_q;
            udn_q     <= next_udn_q;
            rd_n_q    <= rd_n_i;
            wr_n_q    <= wr_n_i;
            fl_cnt    <= next_fl_cnt;
            flush_q   <= next_flush_q;
        end
    end

    assign data_o                   = pin_q;
    assign data_oe_o                = oe_q;
    assign sample_done_strobe_n_o   = sdn_q;
    assign output_update_strobe_n_o = udn_q;
    assign flush_o                  = flush_q;
endmodule // ccbb_port
`default_nettype wire

//--- ccbb_pkg.sv
// shared constants and types for the channel cpu fifo and bit-bang port
package ccbb_pkg;
    localparam int DATA_W = 8;
    // mode-select codes
    localparam logic [7:0] MODE_RESET      = 8'h00;
    localparam logic [7:0] MODE_ASYNC_BANG = 8'h01;
    localparam logic [7:0] MODE_SYNC_BANG  = 8'h04;
    // status byte bit positions
    localparam int ST_RXF  = 0;
    localparam int ST_TXE  = 1;
    localparam int ST_SUSP = 2;
    localparam int ST_CFG  = 3;
    localparam logic [3:0] ST_UPPER = 4'h0;
    // cpu port address decode
    localparam logic ADDR_DATA   = 1'b0;
    localparam logic ADDR_STATUS = 1'b1;
    // timing
    localparam int CLK_MHZ       = 200;
    localparam int FLUSH_PULSE_NS = 250;
    localparam int FLUSH_CYC     = (FLUSH_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0010;
    localparam logic [7:0]  DIR_RST      = 8'h00;

    typedef enum logic [1:0] {
        CCBB_FIFO_OFF,
        CCBB_FIFO_CPU
    } ccbb_cfg_e;

    typedef struct packed {
        logic [7:0] code;
        logic [7:0] dir_mask;
    } ccbb_mode_cmd_s;

    typedef struct packed {
        logic rx_avail;
        logic tx_space;
        logic suspend;
        logic configured;
    } ccbb_usb_state_s;
endpackage : ccbb_pkg

//--- ccbb_buf2.sv
// two-entry valid/ready buffer
`timescale 1ns/1ps
`default_nettype none
module ccbb_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [WIDTH-1:0]      out_data_o
);
    // single-bit pointers serve exactly two slots
    if (DEPTH != 2 || WIDTH < 1)
    begin : g_bad_cfg
        $error("ccbb_buf2 supports depth 2 only");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic             wp;
    logic             rp;
    logic [1:0]       cnt;
    logic             next_wp;
    logic             next_rp;
    logic [1:0]       next_cnt;
    logic             push;
    logic             pop;

    assign in_ready_o  = (cnt != 2'd2);
    assign out_valid_o = (cnt != 2'd0);
    assign out_data_o  = mem[rp];

    always_comb
    begin
        push     = in_valid_i && in_ready_o;
        pop      = out_valid_o && out_ready_i;
        next_mem = mem;
        next_wp  = wp;
        next_rp  = rp;
        next_cnt = cnt;
        if (push)
        begin
            next_mem[wp] = in_data_i;
            next_wp      = ~wp;
        end
        if (pop)
            next_rp = ~rp;
        if (push && !pop)
            next_cnt = cnt + 2'd1;
        else if (pop && !push)
            next_cnt = cnt - 2'd1;
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            wp  <= 1'b0;
            rp  <= 1'b0;
            cnt <= 2'd0;
            for (int i = 0; i < DEPTH; i++)
                mem[i] <= '0;
        end
        else
        begin
            wp  <= next_wp;
            rp  <= next_rp;
            cnt <= next_cnt;
            mem <= next_mem;
        end
    end
endmodule // ccbb_buf2
`default_nettype wire

//--- ccbb_baud.sv
// baud tick divider producing one-cycle enable pulses
`timescale 1ns/1ps
`default_nettype none
module ccbb_baud #(
    parameter int DIV_W = 16
) (
    input  wire logic             ref_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [DIV_W-1:0] div_i,
    output logic                  tick_o
);
    if (DIV_W < 2)
    begin : g_bad_cfg
        $error("ccbb_baud divider too narrow");
    end

    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] next_cnt;
    logic             next_tick;

    always_comb
    begin
        next_tick = 1'b0;
        next_cnt  = cnt + 1'b1;
        if (cnt >= div_i)
        begin
            next_cnt  = '0;
            next_tick = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            cnt    <= '0;
            tick_o <= 1'b0;
        end
        else
        begin
            cnt    <= next_cnt;
            tick_o <= next_tick;
        end
    end
endmodule // ccbb_baud
`default_nettype wire

//--- ccbb_port_checker.sv
// concurrent checks on the channel port pins
`timescale 1ns/1ps
`default_nettype none
module ccbb_port_checker (
    input wire logic                     ref_clk_i,
    input wire logic                     rst_n_i,
    input wire logic                     mode_cmd_valid_i,
    input wire ccbb_pkg::ccbb_mode_cmd_s mode_cmd_i,
    input wire logic                     rx_valid_i,
    input wire logic                     rx_ready_o,
    input wire logic                     tx_valid_o,
    input wire logic                     flush_o,
    input wire logic                     cs_n_i,
    input wire logic                     port_address_bit_i,
    input wire logic                     rd_n_i,
    input wire logic [7:0]               data_o,
    input wire logic [7:0]               data_oe_o,
    input wire logic                     sample_done_strobe_n_o,
    input wire logic                     output_update_strobe_n_o
);
    logic [7:0] mode, next_mode, dir, next_dir, fcnt, next_fcnt;
    logic [1:0] vd, next_vd;
    logic       sm, am, bang, calm;
    always_comb
    begin
        next_mode = mode;
        next_dir  = dir;
        if (mode_cmd_valid_i)
        begin
            next_dir  = mode_cmd_i.dir_mask;
            next_mode = mode_cmd_i.code;
        end
        next_fcnt = flush_o ? fcnt + 8'h01 : 8'h00;
        next_vd   = {vd[0], mode_cmd_valid_i};
    end
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            mode <= 8'h00;
            dir  <= 8'h00;
            fcnt <= 8'h00;
            vd   <= 2'b00;
        end
        else
        begin
            mode <= next_mode;
            dir  <= next_dir;
            fcnt <= next_fcnt;
            vd   <= next_vd;
        end
    end
    // unknown codes fall back to fifo, so only the two bang codes count
    assign sm   = mode == ccbb_pkg::MODE_SYNC_BANG;
    assign am   = mode == ccbb_pkg::MODE_ASYNC_BANG;
    assign bang = sm || am;
    assign calm = vd == 2'b00 && !mode_cmd_valid_i;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);
    upd_pulse_a: assert property (
        !output_update_strobe_n_o |=> output_update_strobe_n_o)
        else $error("update strobe too long");
    smp_pulse_a: assert property (
        !sample_done_strobe_n_o |=> sample_done_strobe_n_o)
        else $error("sample strobe too long");
    sync_order_a: assert property (
        (sm && calm && !sample_done_strobe_n_o)
        |-> ##3 !output_update_strobe_n_o)
        else $error("sync update strobe not three after sample");
    sync_cause_a: assert property (
        (sm && calm && !sample_done_strobe_n_o)
        |-> $past(rx_valid_i && rx_ready_o, 2))
        else $error("sync sample without byte");
    sync_push_a: assert property (
        (sm && !sample_done_strobe_n_o) |-> ##[0:2] tx_valid_o)
        else $error("sample not queued");
    sync_upd_a: assert property (
        (sm && calm && $changed(data_o))
        |-> ##2 !output_update_strobe_n_o)
        else $error("sync pins changed without strobe");
    async_chg_a: assert property (
        (am && calm && $changed(data_o)) |->
        (!output_update_strobe_n_o || $past(!output_update_strobe_n_o)))
        else $error("async pins changed without strobe");
    bang_dir_a: assert property (
        (bang && calm) |-> data_oe_o == dir)
        else $error("pin direction differs from mask");
    flush_max_a: assert property (
        flush_o |-> fcnt < 8'(ccbb_pkg::FLUSH_CYC))
        else $error("flush too long");
    flush_len_a: assert property (
        $fell(flush_o) |-> fcnt == 8'(ccbb_pkg::FLUSH_CYC))
        else $error("flush too short");
    flush_src_a: assert property (
        $rose(flush_o) |-> $past(!cs_n_i && port_address_bit_i))
        else $error("flush without selected write");
    oe_src_a: assert property (
        (!bang && calm && |data_oe_o) |-> $past(!cs_n_i && !rd_n_i))
        else $error("fifo mode drive without read");
    cover property (sm && !output_update_strobe_n_o);
    cover property (am && !output_update_strobe_n_o);
    cover property ($fell(flush_o));
endmodule // ccbb_port_checker
bind ccbb_port ccbb_port_checker i_chk (.ref_clk_i, .rst_n_i,
    .mode_cmd_valid_i, .mode_cmd_i, .rx_valid_i, .rx_ready_o,
    .tx_valid_o, .flush_o, .cs_n_i, .port_address_bit_i, .rd_n_i,
    .data_o, .data_oe_o, .sample_done_strobe_n_o,
    .output_update_strobe_n_o);
`default_nettype wire

//--- ccbb_pin_model.sv
// external glue on the eight data lines
`timescale 1ns/1ps
`default_nettype none
module ccbb_pin_model (
    input  wire logic [7:0] drv_i,
    input  wire logic [7:0] oe_i,
    input  wire logic [7:0] ext_i,
    output logic      [7:0] pins_o
);
    // per-line resolve, outside value where port does not drive
    assign pins_o = (drv_i & oe_i) | (ext_i & ~oe_i);
endmodule // ccbb_pin_model
`default_nettype wire

//--- ccbb_port_tb.sv
// self-checking bench for the channel port
`timescale 1ns/1ps
`default_nettype none
module ccbb_port_tb;
    logic                      ref_clk_i = 1'b0;
    logic                      rst_n_i = 1'b0;
    ccbb_pkg::ccbb_cfg_e       cfg = ccbb_pkg::CCBB_FIFO_CPU;
    ccbb_pkg::ccbb_mode_cmd_s  mc = '0;
    ccbb_pkg::ccbb_usb_state_s us = '0;
    logic                      mv = 0, rxv = 0, txr = 1, cs_n = 1, a0 = 0;
    logic                      rd_n = 1, wr_n = 1, rxr, txv, fl, ss, us_n;
    logic [7:0]                rxd = 0, ext = 8'hA0, pins, dout, oe, txd;
    logic [7:0]                q, qoe, txq[$];
    int                        error_cnt = 0, compares = 0;
    int                        takes = 0, flc = 0, n0, upd = 0;
    ccbb_port i_dut (.ref_clk_i, .rst_n_i, .cfg_mode_i(cfg),
        .mode_cmd_valid_i(mv), .mode_cmd_i(mc), .baud_div_i(16'h0003),
        .usb_state_i(us), .rx_valid_i(rxv), .rx_ready_o(rxr),
        .rx_data_i(rxd), .tx_valid_o(txv), .tx_ready_i(txr),
        .tx_data_o(txd), .flush_o(fl), .cs_n_i(cs_n),
        .port_address_bit_i(a0), .rd_n_i(rd_n), .wr_n_i(wr_n),
        .data_i(pins), .data_o(dout), .data_oe_o(oe),
        .sample_done_strobe_n_o(ss), .output_update_strobe_n_o(us_n));
    ccbb_pin_model i_pins (.drv_i(dout), .oe_i(oe), .ext_i(ext),
        .pins_o(pins));
    always #2.5 ref_clk_i = ~ref_clk_i;
    // sampled mid-cycle, ahead of the edge that takes them
    always @(negedge ref_clk_i)
    begin
        if (rxv && rxr === 1'b1)
            takes++;
        if (txv === 1'b1 && txr)
            txq.push_back(txd);
        if (fl === 1'b1)
            flc++;
        if (us_n === 1'b0)
            upd++;
    end
    task automatic chk(input string n, input logic [7:0] e,
                       input logic [7:0] g);
        compares++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic wrap_up;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask
    task automatic send_rx(input logic [7:0] b);
        int n;
        n = takes;
        tick(1);
        rxv <= 1'b1;
        rxd <= b;
        for (int i = 0; i < 200 && takes == n; i++)
            tick(1);
        rxv <= 1'b0;
    endtask
    task automatic mode(input logic [7:0] c, input logic [7:0] d);
        tick(1);
        mv <= 1'b1;
        mc <= '{code: c, dir_mask: d};
        tick(1);
        mv <= 1'b0;
        tick(4);
        txq.delete();
    endtask
    task automatic cpu(input logic c, input logic a, input logic w,
                       input logic [7:0] d);
        tick(1);
        cs_n <= c;
        a0 <= a;
        ext <= d;
        tick(1);
        wr_n <= !w;
        rd_n <= w;
        tick(3);
        @(negedge ref_clk_i);
        q = dout;
        qoe = oe;
        tick(1);
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        tick(1);
        cs_n <= 1'b1;
        tick(2);
    endtask
    initial
    begin
        tick(16);
        rst_n_i <= 1'b1;
        mode(ccbb_pkg::MODE_SYNC_BANG, 8'h0F);
        txr <= 1'b0;
        n0 = takes;
        send_rx(8'h55);
        send_rx(8'hAA);
        tick(1);
        rxv <= 1'b1;
        tick(30);
        chk("stalled takes", 8'd2, 8'(takes - n0));
        txr <= 1'b1;
        for (int i = 0; i < 100 && takes - n0 < 3; i++)
            tick(1);
        rxv <= 1'b0;
        tick(30);
        chk("sample count", 8'd3, 8'(txq.size()));
        chk("sample 0", 8'hA0, txq[0]);
        chk("sample 1", 8'hA5, txq[1]);
        chk("sample 2", 8'hAA, txq[2]);
        chk("sync pins", 8'hAA, pins);
        chk("update strobes", 8'd3, 8'(upd));
        mode(ccbb_pkg::MODE_SYNC_BANG, 8'h00);
        send_rx(8'h33);
        tick(20);
        chk("input sample", 8'hA0, txq[0]);
        chk("input pins", 8'hA0, pins);
        $display("test sync bang done");
        mode(ccbb_pkg::MODE_ASYNC_BANG, 8'hFF);
        send_rx(8'h3C);
        tick(10);
        chk("async pins", 8'h3C, pins);
        chk("async strobes", 8'd5, 8'(upd));
        tick(40);
        chk("async hold", 8'h3C, pins);
        $display("test async bang done");
        mode(ccbb_pkg::MODE_RESET, 8'h00);
        cpu(1'b0, ccbb_pkg::ADDR_DATA, 1'b1, 8'h5A);
        cpu(1'b1, ccbb_pkg::ADDR_DATA, 1'b1, 8'h66);
        tick(5);
        chk("tx count", 8'd1, 8'(txq.size()));
        chk("tx byte", 8'h5A, txq[0]);
        us <= 4'b1010;
        cpu(1'b0, ccbb_pkg::ADDR_STATUS, 1'b0, 8'h00);
        chk("status a", 8'h05, q & 8'h0F);
        chk("status a high", 8'h00, q & 8'hF0);
        us <= 4'b0101;
        cpu(1'b0, ccbb_pkg::ADDR_STATUS, 1'b0, 8'h00);
        chk("status b", 8'h0A, q & 8'h0F);
        rxv <= 1'b1;
        rxd <= 8'hC3;
        cpu(1'b0, ccbb_pkg::ADDR_DATA, 1'b0, 8'h00);
        rxv <= 1'b0;
        chk("pipe read", 8'hC3, q);
        chk("read drive", 8'hFF, qoe);
        cpu(1'b0, ccbb_pkg::ADDR_STATUS, 1'b1, 8'h00);
        tick(80);
        chk("flush cycles", 8'd50, 8'(flc));
        cpu(1'b1, ccbb_pkg::ADDR_STATUS, 1'b1, 8'h00);
        tick(80);
        chk("flush ignored", 8'd50, 8'(flc));
        cfg <= ccbb_pkg::CCBB_FIFO_OFF;
        cpu(1'b0, ccbb_pkg::ADDR_STATUS, 1'b0, 8'h00);
        chk("no cpu mode", 8'h00, qoe);
        $display("test cpu fifo done");
        wrap_up();
    end
    initial
    begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule // ccbb_port_tb
`default_nettype wire
